//--- test/hss_axis_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural axis: turns the profile command into position, switches and index
module hss_axis_model
   import hss_pkg::*;
#(
   parameter int HS_LO = 220, // first count with the home switch on
   parameter int HS_HI = 300, // last count with the home switch on
   parameter int PLIM_AT = 1000, // positive limit active at and above
   parameter int NLIM_AT = -1000 // negative limit active at and below
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire hss_profile_s profile_in,
   input wire logic load_in, // place the axis and clear the counters
   input wire logic [31:0] load_pos_in,
   input wire logic hs_off_in, // removes the home switch from the axis
   output logic [31:0] pos_out,
   output logic stopped_out,
   output logic plim_out,
   output logic nlim_out,
   output logic hs_out,
   output logic idx_out,
   output logic dir_out, // direction of the last leg
   output logic [7:0] rev_out, // direction changes since load
   output logic [7:0] viol_out // direction changes while moving
);
   logic signed [31:0] pos_reg; // axis position
   logic signed [31:0] step_w; // counts per cycle
   logic [2:0] dcnt_reg; // cycles of ramp still to go
   logic fresh_reg; // no leg since load
   // fast legs move four counts a cycle, creep one
   assign step_w = profile_in.high_speed ? 32'sh4 : 32'sh1;
   assign pos_out = pos_reg;
   assign plim_out = (pos_reg >= PLIM_AT);
   assign nlim_out = (pos_reg <= NLIM_AT);
   assign hs_out = !hs_off_in && (pos_reg >= HS_LO) && (pos_reg <= HS_HI);
   // index window four counts wide, so a creep pass holds it four cycles
   assign idx_out = (pos_reg[5:0] < 6'h4);
   // motion, ramp-down and reversal bookkeeping
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pos_reg <= '0;
         dcnt_reg <= '0;
         stopped_out <= 1'b1;
         fresh_reg <= 1'b1;
         dir_out <= 1'b0;
         rev_out <= '0;
         viol_out <= '0;
      end else if (load_in) begin
         pos_reg <= load_pos_in;
         dcnt_reg <= '0;
         stopped_out <= 1'b1;
         fresh_reg <= 1'b1;
         rev_out <= '0;
         viol_out <= '0;
      end else if (profile_in.run) begin
         pos_reg <= profile_in.dir_pos ? pos_reg + step_w : pos_reg - step_w;
         stopped_out <= 1'b0;
         dcnt_reg <= 3'h3;
         dir_out <= profile_in.dir_pos;
         fresh_reg <= 1'b0;
         // a turn counts; a turn without standing still first is a fault
         if (!fresh_reg && profile_in.dir_pos != dir_out) begin
            rev_out <= rev_out + 8'h1;
            if (!stopped_out) begin
               viol_out <= viol_out + 8'h1;
            end
         end
      end else if (dcnt_reg != 3'h0) begin
         dcnt_reg <= dcnt_reg - 3'h1;
      end else begin
         stopped_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- test/hss_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// homing runs over every method against the axis model
module hss_sequencer_tb_top
   import hss_pkg::*;
;
   logic sys_clk_in, rst_b_in, start_in, load_in, hs_off_in;
   logic [3:0] method_in;
   logic [31:0] load_pos_in, origin_out, pos_w;
   logic [31:0] hi_cfg = 32'h0000_1000; // search speed
   logic [31:0] lo_cfg = 32'h0000_0100; // creep speed
   logic [31:0] dr_cfg = 32'h0000_0040; // deceleration
   hss_profile_s profile_out;
   logic homing_done_out, alarm_out, busy_out;
   logic plim_w, nlim_w, hs_w, idx_w, stop_w, dir_w;
   logic [7:0] rev_w, viol_w;
   int err_total = 0;
   int n_compared = 0;
   hss_sequencer i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .start_in(start_in),
      .method_in(method_in), .positive_limit_input_in(plim_w), .negative_limit_input_in(nlim_w),
      .home_switch_input_in(hs_w), .index_pulse_in(idx_w), .position_in(pos_w),
      .motion_stopped_in(stop_w), .high_speed_in(hi_cfg), .low_speed_in(lo_cfg),
      .decel_rate_in(dr_cfg), .profile_out(profile_out), .origin_out(origin_out),
      .homing_done_out(homing_done_out), .alarm_out(alarm_out), .busy_out(busy_out));
   hss_axis_model i_axis (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .profile_in(profile_out), .load_in(load_in), .load_pos_in(load_pos_in),
      .hs_off_in(hs_off_in), .pos_out(pos_w), .stopped_out(stop_w), .plim_out(plim_w),
      .nlim_out(nlim_w), .hs_out(hs_w), .idx_out(idx_w), .dir_out(dir_w), .rev_out(rev_w),
      .viol_out(viol_w));
   // 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   // one comparison, counted
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // counts, verdict and stop
   task automatic end_of_test();
      $display("compared=%0d errors=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // speed and ramp always come from the live settings; looked at mid-cycle, once settled
   always @(negedge sys_clk_in) begin
      if (rst_b_in === 1'b1 && profile_out.run === 1'b1) begin
         check(profile_out.speed, profile_out.high_speed ? hi_cfg : lo_cfg);
      end
      if (rst_b_in === 1'b1 && profile_out.decel === 1'b1) begin
         check(profile_out.decel_rate, dr_cfg);
      end
   end
   // one homing run from a given place; p0 is the first index met after the final edge
   // jump, when not 0, puts the axis back on the positive limit at that wait cycle
   task automatic home(input logic [3:0] m, input int start, input logic hs_off,
         input logic exp_alarm, input int exp_rev, input logic exp_dir, input int p0,
         input int jump = 0);
      int i;
      logic signed [31:0] d;
      @(negedge sys_clk_in);
      load_in = 1'b1;
      load_pos_in = start;
      hs_off_in = hs_off;
      @(negedge sys_clk_in);
      load_in = 1'b0;
      // let the pins through the synchroniser
      repeat (4) @(negedge sys_clk_in);
      start_in = 1'b1;
      method_in = m;
      @(negedge sys_clk_in);
      start_in = 1'b0;
      i = 0;
      while (busy_out !== 1'b0 && i < 20000) begin
         @(negedge sys_clk_in);
         i++;
         // one-cycle placement of the axis onto the positive limit
         load_in = (i == jump);
         load_pos_in = 32'h0000_03f2;
      end
      if (i >= 20000) begin
         check(32'h1, 32'h0);
         end_of_test();
      end else begin
         repeat (2) @(negedge sys_clk_in);
         check(32'(alarm_out), 32'(exp_alarm));
         check(32'(homing_done_out), 32'(!exp_alarm));
         check(32'(profile_out.run), 32'h0);
         check(32'(viol_w), 32'h0);
         if (!exp_alarm) begin
            check(32'(rev_w), exp_rev);
            check(32'(dir_w), 32'(exp_dir));
            d = exp_dir ? $signed(origin_out) - p0 : p0 - $signed(origin_out);
            check(32'(d >= 0 && d <= 8), 32'h1);
         end
      end
   endtask
   task automatic t_method2();
      home(4'h2, 0, 1'b0, 1'b0, 1, 1'b0, 963);
      home(4'h2, 1010, 1'b0, 1'b0, 0, 1'b0, 963);
   endtask
   task automatic t_method3();
      home(4'h3, 0, 1'b0, 1'b0, 1, 1'b0, 195);
      home(4'h3, 250, 1'b0, 1'b0, 2, 1'b0, 195);
   endtask
   task automatic t_method4();
      home(4'h4, 0, 1'b0, 1'b0, 2, 1'b1, 256);
      home(4'h4, 250, 1'b0, 1'b0, 1, 1'b1, 256);
   endtask
   task automatic t_method5();
      // new speed settings while idle, picked up live
      hi_cfg = 32'h0000_2000;
      lo_cfg = 32'h0000_0200;
      home(4'h5, 400, 1'b0, 1'b0, 1, 1'b1, 320);
      home(4'h5, 250, 1'b0, 1'b0, 2, 1'b1, 320);
   endtask
   task automatic t_method6();
      home(4'h6, 400, 1'b0, 1'b0, 2, 1'b0, 259);
      home(4'h6, 250, 1'b0, 1'b0, 1, 1'b0, 259);
   endtask
   // aborts; the run after the last one must clear the alarm
   task automatic t_aborts();
      home(4'h3, 1010, 1'b0, 1'b1, 0, 1'b0, 0);
      home(4'h5, -900, 1'b0, 1'b1, 0, 1'b0, 0);
      home(4'h7, -1010, 1'b0, 1'b1, 0, 1'b0, 0);
      home(4'h7, 500, 1'b1, 1'b1, 0, 1'b0, 0);
      home(4'h8, 500, 1'b1, 1'b1, 0, 1'b0, 0, 300);
      home(4'h9, 0, 1'b0, 1'b1, 0, 1'b0, 0);
   endtask
   task automatic t_method7();
      home(4'h7, 500, 1'b0, 1'b0, 3, 1'b0, 195);
      home(4'h7, 0, 1'b0, 1'b0, 1, 1'b0, 195);
   endtask
   task automatic t_method8();
      home(4'h8, 500, 1'b0, 1'b0, 2, 1'b1, 256);
      home(4'h8, 0, 1'b0, 1'b0, 2, 1'b1, 256);
   endtask
   // reset, then every scenario in turn
   initial begin
      rst_b_in = 1'b0;
      start_in = 1'b0;
      method_in = 4'h0;
      load_in = 1'b0;
      load_pos_in = 32'h0;
      hs_off_in = 1'b0;
      repeat (20) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      // busy, alarm, done, run, decel and origin quiet after reset
      @(negedge sys_clk_in);
      check(32'({busy_out, alarm_out, homing_done_out}), 32'h0);
      check(32'({profile_out.run, profile_out.decel}), 32'h0);
      check(origin_out, 32'h0);
      t_method2();
      t_method3();
      t_method4();
      t_method5();
      t_method6();
      t_aborts();
      t_method7();
      t_method8();
      end_of_test();
   end
endmodule
`default_nettype wire

//--- verilog/hss_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser plus edge detection for the axis pins
module hss_pin_sync
   import hss_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [HSS_PIN_COUNT-1:0] pins_in,
   output logic [HSS_PIN_COUNT-1:0] level_out,
   output logic [HSS_PIN_COUNT-1:0] rise_out,
   output logic [HSS_PIN_COUNT-1:0] fall_out
);
   logic [HSS_PIN_COUNT-1:0] meta_reg; // first stage, read only by second
   logic [HSS_PIN_COUNT-1:0] sync_reg; // second stage, safe level
   logic [HSS_PIN_COUNT-1:0] prev_reg; // delayed copy for edges

   genvar g;
   generate
      for (g = 0; g < HSS_PIN_COUNT; g++) begin : g_pin
         // per-pin flop chain
         always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
               prev_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= pins_in[g];
               sync_reg[g] <= meta_reg[g];
               prev_reg[g] <= sync_reg[g];
            end
         end
      end
   endgenerate

   // edges come from the settled stages only
   assign level_out = sync_reg;
   assign rise_out = sync_reg & ~prev_reg;
   assign fall_out = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

//--- verilog/hss_pkg.sv
`default_nettype none
// shared constants and types for the homing switch sequencer
package hss_pkg;
   // pin slot positions in the synchroniser vector
   localparam int HSS_PIN_COUNT = 4;
   localparam int HSS_PIN_POS_LIM = 0; // positive limit
   localparam int HSS_PIN_NEG_LIM = 1; // negative limit
   localparam int HSS_PIN_HS = 2; // home switch
   localparam int HSS_PIN_IDX = 3; // encoder index
   // synchroniser depth in flip-flops
   localparam int HSS_SYNC_STAGES = 2;
   // data widths
   localparam int HSS_POS_W = 32;
   localparam int HSS_SPD_W = 32;
   localparam int HSS_METHOD_W = 4;
   // supported method codes
   localparam logic [3:0] HSS_M2 = 4'h2;
   localparam logic [3:0] HSS_M3 = 4'h3;
   localparam logic [3:0] HSS_M4 = 4'h4;
   localparam logic [3:0] HSS_M5 = 4'h5;
   localparam logic [3:0] HSS_M6 = 4'h6;
   localparam logic [3:0] HSS_M7 = 4'h7;
   localparam logic [3:0] HSS_M8 = 4'h8;
   // values after reset
   localparam logic [31:0] HSS_POS_RST = 32'h0;
   localparam logic [3:0] HSS_SYNC_RST = 4'h0;
   // sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_SEEK  = 8'h02,
      ST_BACK  = 8'h04,
      ST_CREEP = 8'h08,
      ST_INDEX = 8'h10,
      ST_STOP  = 8'h20,
      ST_DONE  = 8'h40,
      ST_FAULT = 8'h80
   } hss_state_e;
   // command to the motion profile generator
   typedef struct packed {
      logic run;
      logic decel;
      logic high_speed;
      logic dir_pos;
      logic [31:0] speed;
      logic [31:0] decel_rate;
   } hss_profile_s;
   localparam hss_profile_s HSS_PROFILE_RST = '0;
   // per-method behaviour
   typedef struct packed {
      logic valid;
      logic fe_rise;     // final edge is rising
      logic cd_pos;      // creep direction positive
      logic use_lim;     // positive limit acts as the switch
      logic rev_en;      // reverse on first positive limit
      logic abort_both;  // either limit aborts
      logic abort_neg;   // negative limit aborts
   } hss_cfg_s;
   localparam hss_cfg_s HSS_CFG_RST = '0;
endpackage
`default_nettype wire

//--- verilog/hss_sequencer.sv
// Functional notes
// - method 2 clear limit: fast positive, stop, creep back
// - method 2 limit active: creep negative past release
// - after final edge creep on, latch first index
// - method 3 clear: fast positive, stop, creep negative
// - method 3 active: fast out, back in, creep negative
// - method 4 clear: fast in, back out, creep positive
// - method 4 active: fast negative out, creep positive
// - method 5 clear: fast negative in, creep positive
// - method 5 active: fast out, back in, creep positive
// - method 6 clear: fast in, back out, creep negative
// - method 6 active: fast positive out, creep negative
// - methods 3-6: any limit aborts with alarm
// - methods 7-8: positive limit reverses after stopping
// - method 7: negative or second positive limit aborts
// - method 7 ends falling edge, travelling negative
// - method 8 ends rising edge, travelling positive
// - method 8: second positive limit aborts
`timescale 1ns/100ps
`default_nettype none
module hss_sequencer
   import hss_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic start_in, // one-cycle start request
   input wire logic [HSS_METHOD_W-1:0] method_in, // method code sampled at start
   input wire logic positive_limit_input_in, // asynchronous pin
   input wire logic negative_limit_input_in, // asynchronous pin
   input wire logic home_switch_input_in, // asynchronous pin
   input wire logic index_pulse_in, // asynchronous pin
   input wire logic [HSS_POS_W-1:0] position_in, // encoder count, same clock
   input wire logic motion_stopped_in, // profile at zero speed
   input wire logic [HSS_SPD_W-1:0] high_speed_in, // search speed
   input wire logic [HSS_SPD_W-1:0] low_speed_in, // creep speed
   input wire logic [HSS_SPD_W-1:0] decel_rate_in, // deceleration
   output hss_profile_s profile_out,
   output logic [HSS_POS_W-1:0] origin_out,
   output logic homing_done_out,
   output logic alarm_out,
   output logic busy_out
);
   // method table
   function automatic hss_cfg_s hss_decode(input logic [HSS_METHOD_W-1:0] m);
      hss_cfg_s c;
      c = HSS_CFG_RST;
      c.valid = 1'b1;
      unique case (m)
         HSS_M2: c.use_lim = 1'b1; // limit is the switch, fall, negative
         HSS_M3: c.abort_both = 1'b1;
         HSS_M4: begin
            c.fe_rise = 1'b1;
            c.cd_pos = 1'b1;
            c.abort_both = 1'b1;
         end
         HSS_M5: begin
            c.cd_pos = 1'b1;
            c.abort_both = 1'b1;
         end
         HSS_M6: begin
            c.fe_rise = 1'b1;
            c.abort_both = 1'b1;
         end
         HSS_M7: begin
            c.rev_en = 1'b1;
            c.abort_neg = 1'b1;
         end
         HSS_M8: begin
            c.fe_rise = 1'b1;
            c.cd_pos = 1'b1;
            c.rev_en = 1'b1;
         end
         default: c.valid = 1'b0;
      endcase
      return c;
   endfunction

   // synchronised pins
   logic [HSS_PIN_COUNT-1:0] pin_lvl;
   logic [HSS_PIN_COUNT-1:0] pin_rise;
   logic [HSS_PIN_COUNT-1:0] pin_fall;

   hss_pin_sync u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .pins_in({index_pulse_in, home_switch_input_in, negative_limit_input_in,
                positive_limit_input_in}),
      .level_out(pin_lvl),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   // state and working registers
   hss_state_e state_reg, state_next;
   hss_state_e after_reg, after_next; // state to take once stopped
   hss_cfg_s cfg_reg, cfg_next; // method of the running sequence
   logic dir_reg, dir_next; // travel direction, 1 is positive
   logic erise_reg, erise_next; // fast leg waits for a rising edge
   logic pass_reg, pass_next; // after reversal, ride through the switch
   logic hits_reg, hits_next; // first positive limit already seen
   logic done_reg, done_next;
   logic alarm_reg, alarm_next;
   logic [HSS_POS_W-1:0] origin_reg, origin_next;
   logic busy_next;
   hss_profile_s profile_reg, profile_next;

   // decoded conditions
   wire plim_lvl = pin_lvl[HSS_PIN_POS_LIM];
   wire nlim_lvl = pin_lvl[HSS_PIN_NEG_LIM];
   wire plim_rise = pin_rise[HSS_PIN_POS_LIM];
   wire idx_rise = pin_rise[HSS_PIN_IDX];
   wire hs_lvl = pin_lvl[HSS_PIN_HS];
   // switch that marks the origin for this method
   wire sw_rise = cfg_reg.use_lim ? pin_rise[HSS_PIN_POS_LIM] : pin_rise[HSS_PIN_HS];
   wire sw_fall = cfg_reg.use_lim ? pin_fall[HSS_PIN_POS_LIM] : pin_fall[HSS_PIN_HS];
   // start-time view
   hss_cfg_s start_cfg;
   assign start_cfg = hss_decode(method_in);
   wire start_lvl = start_cfg.use_lim ? plim_lvl : hs_lvl;
   wire start_erise = ~start_lvl; // clear switch: look for it coming on
   // fast leg direction: toward the edge if it is the final one
   wire start_dir = (start_erise == start_cfg.fe_rise) ? start_cfg.cd_pos : ~start_cfg.cd_pos;
   // edge hits
   wire seek_hit = erise_reg ? sw_rise : sw_fall;
   wire final_hit = cfg_reg.fe_rise ? sw_rise : sw_fall;
   // abort causes
   wire abort_hit = (cfg_reg.abort_both & (plim_lvl | nlim_lvl))
                  | (cfg_reg.abort_neg & nlim_lvl)
                  | (cfg_reg.rev_en & hits_reg & plim_rise);
   // first positive limit while moving fast in positive direction
   wire fast_st = (state_reg == ST_SEEK) || (state_reg == ST_BACK);
   wire slow_st = (state_reg == ST_CREEP) || (state_reg == ST_INDEX);
   wire rev_hit = cfg_reg.rev_en & ~hits_reg & plim_rise & dir_reg & fast_st;
   wire idle_st = (state_reg == ST_IDLE) || (state_reg == ST_DONE) || (state_reg == ST_FAULT);

   // next-state logic
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      cfg_next = cfg_reg;
      dir_next = dir_reg;
      erise_next = erise_reg;
      pass_next = pass_reg;
      hits_next = hits_reg;
      done_next = done_reg;
      alarm_next = alarm_reg;
      origin_next = origin_reg;
      unique case (state_reg)
         // waiting for a start; flags hold until then
         ST_IDLE, ST_DONE, ST_FAULT: begin
            if (start_in) begin
               cfg_next = start_cfg;
               done_next = 1'b0;
               alarm_next = 1'b0;
               hits_next = 1'b0;
               pass_next = 1'b0;
               erise_next = start_erise;
               if (!start_cfg.valid) begin
                  state_next = ST_FAULT;
                  alarm_next = 1'b1;
               end else if (start_cfg.use_lim && start_lvl) begin
                  state_next = ST_CREEP;
                  dir_next = start_cfg.cd_pos;
               end else begin
                  state_next = ST_SEEK;
                  dir_next = start_dir;
               end
            end
         end
         // fast legs
         ST_SEEK, ST_BACK: begin
            if (abort_hit) begin
               state_next = ST_FAULT;
               alarm_next = 1'b1;
               done_next = 1'b0;
            end else if (rev_hit) begin
               hits_next = 1'b1;
               erise_next = 1'b1;
               pass_next = 1'b1;
               after_next = ST_SEEK;
               state_next = ST_STOP;
            end else if (seek_hit && pass_reg) begin
               pass_next = 1'b0; // now inside the switch, run on to its far edge
               erise_next = 1'b0;
            end else if (seek_hit) begin
               state_next = ST_STOP;
               erise_next = ~erise_reg;
               // edge equal to the final one means back off and approach again
               if (state_reg == ST_SEEK && erise_reg == cfg_reg.fe_rise) begin
                  after_next = ST_BACK;
               end else begin
                  after_next = ST_CREEP;
               end
            end
         end
         // slow approach to the final edge
         ST_CREEP: begin
            if (abort_hit) begin
               state_next = ST_FAULT;
               alarm_next = 1'b1;
            end else if (final_hit) begin
               state_next = ST_INDEX;
            end
         end
         // keep creeping until the index pulse
         ST_INDEX: begin
            if (abort_hit) begin
               state_next = ST_FAULT;
               alarm_next = 1'b1;
            end else if (idx_rise) begin
               origin_next = position_in;
               done_next = 1'b1;
               after_next = ST_DONE;
               state_next = ST_STOP;
            end
         end
         // decelerate to zero before anything but an abort
         ST_STOP: begin
            if (abort_hit) begin
               state_next = ST_FAULT;
               alarm_next = 1'b1;
               done_next = 1'b0;
            end else if (motion_stopped_in) begin
               state_next = after_reg;
               if (after_reg == ST_CREEP) begin
                  dir_next = cfg_reg.cd_pos;
               end else if (after_reg == ST_BACK || after_reg == ST_SEEK) begin
                  dir_next = ~dir_reg;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // profile command, speeds taken live from the inputs
   assign busy_next = ~((state_next == ST_IDLE) || (state_next == ST_DONE)
                        || (state_next == ST_FAULT));
   assign profile_next.run = fast_st | slow_st;
   assign profile_next.decel = (state_reg == ST_STOP) || (state_reg == ST_FAULT);
   assign profile_next.high_speed = fast_st;
   assign profile_next.dir_pos = dir_reg;
   assign profile_next.speed = fast_st ? high_speed_in : (slow_st ? low_speed_in : '0);
   assign profile_next.decel_rate = decel_rate_in;

   // sequencer registers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_IDLE;
         after_reg <= ST_IDLE;
         cfg_reg <= HSS_CFG_RST;
         dir_reg <= 1'b0;
         erise_reg <= 1'b0;
         pass_reg <= 1'b0;
         hits_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         cfg_reg <= cfg_next;
         dir_reg <= dir_next;
         erise_reg <= erise_next;
         pass_reg <= pass_next;
         hits_reg <= hits_next;
      end
   end

   // output registers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_reg <= 1'b0;
         alarm_reg <= 1'b0;
         origin_reg <= HSS_POS_RST;
         profile_reg <= HSS_PROFILE_RST;
         busy_out <= 1'b0;
      end else begin
         done_reg <= done_next;
         alarm_reg <= alarm_next;
         origin_reg <= origin_next;
         profile_reg <= profile_next;
         busy_out <= busy_next;
      end
   end

   assign profile_out = profile_reg;
   assign origin_out = origin_reg;
   assign homing_done_out = done_reg;
   assign alarm_out = alarm_reg;

   // checks
   a_method2_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      idle_st && start_in && method_in == HSS_M2 && !plim_lvl
      |=> state_reg == ST_SEEK && dir_reg ##1 profile_out.high_speed)
      else $error("method 2 did not start fast positive");
   a_method2_active: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      idle_st && start_in && method_in == HSS_M2 && plim_lvl
      |=> state_reg == ST_CREEP && !dir_reg)
      else $error("method 2 did not creep negative");
   a_origin_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      state_reg == ST_INDEX && idx_rise && !abort_hit
      |=> origin_out == $past(position_in) && homing_done_out)
      else $error("index did not latch origin");
   a_creep_slow: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      slow_st |=> profile_out.run && !profile_out.high_speed
      && profile_out.speed == $past(low_speed_in) && profile_out.dir_pos == cfg_reg.cd_pos)
      else $error("creep not slow in creep direction");
   a_limit_abort: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !idle_st && cfg_reg.abort_both && (plim_lvl || nlim_lvl)
      |=> state_reg == ST_FAULT && alarm_out ##1 profile_out.decel)
      else $error("limit did not abort");
   a_limit_reverse: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      rev_hit && !abort_hit |=> state_reg == ST_STOP && after_reg == ST_SEEK && hits_reg)
      else $error("positive limit did not reverse");
   a_neg_abort: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !idle_st && cfg_reg.abort_neg && nlim_lvl |=> state_reg == ST_FAULT)
      else $error("negative limit did not abort");
   a_limit_second: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !idle_st && cfg_reg.rev_en && hits_reg && plim_rise |=> state_reg == ST_FAULT && alarm_out)
      else $error("second positive limit did not abort");
   a_stop_first: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !idle_st && $past(!idle_st) && dir_reg != $past(dir_reg)
      |-> $past(state_reg) == ST_STOP && $past(motion_stopped_in))
      else $error("direction changed while moving");
   a_alarm_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      alarm_out && !start_in |=> alarm_out)
      else $error("alarm dropped before restart");
   c_done: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) state_reg == ST_DONE);
   c_fault: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) state_reg == ST_FAULT);
   c_back: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) state_reg == ST_BACK);
   c_reverse: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) rev_hit);
endmodule
`default_nettype wire
